// >>> hw/opm_output_mux.sv
// output pin function mux, interrupt request and data bus drive
// Functional notes
// - General output 1 carries channel B request-to-send (active low) when selected.
// - General output 3 selects tx 1X clock, rx 1X clock or open-drain counter ready.
// - General output 5 may be an open-drain low rx-available or fifo-full indicator.
// - General output 7 may be an open-drain low channel B transmitter-ready indicator.
// - General output 6 may be an open-drain low channel A transmitter-ready indicator.
// - All host transfers use one eight-bit data bus, bit 0 least significant.
// - The bus floats while chip select is high except in a vectored acknowledge cycle.
// - Interrupt request (open drain, low) asserts while any enabled condition is present.
// - The request holds until every cause is removed, which the host must do.
// - Master reset drives all general outputs high and stops the counter/timer.
`timescale 1ns/100ps
`include "opm_cfg.svh"
module opm_output_mux
  import opm_pkg::*;
#(
  parameter int NUM_IRQ = 8
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // configuration from the register file
  input wire logic [7:0] gp_latch_in,
  input wire logic op1_alt_in,
  input wire logic [1:0] op3_sel_in,
  input wire logic op5_alt_in,
  input wire logic op5_fifo_full_sel_in,
  input wire logic op6_alt_in,
  input wire logic op7_alt_in,
  input wire logic vectored_mode_in,
  // internal channel and timer status
  input wire logic chan_b_rts_in,
  input wire logic chan_b_tx_unit_clock_in,
  input wire logic chan_b_rx_unit_clock_in,
  input wire logic ct_ready_in,
  input wire logic chan_b_rx_avail_in,
  input wire logic chan_b_fifo_full_in,
  input wire logic chan_b_tx_space_in,
  input wire logic chan_a_tx_space_in,
  input wire logic [NUM_IRQ-1:0] irq_cond_in,
  input wire logic [NUM_IRQ-1:0] irq_mask_in,
  // host bus pins
  input wire logic chip_select_n_in,
  input wire logic read_n_in,
  input wire logic interrupt_ack_cycle_n_in,
  input wire logic [7:0] read_data_in,
  input wire logic [7:0] vector_in,
  input wire logic [7:0] data_bus_in,
  output logic [7:0] data_bus_out,
  output logic data_bus_oe_out,
  output logic [7:0] write_data_out,
  // counter/timer control
  output logic ct_stop_out,
  // output pins; open-drain pins have an enable, high while pulling low
  output logic [7:0] general_output_out,
  output logic [7:0] general_output_oe_out,
  output logic irq_request_n_out,
  output logic irq_request_oe_out
);
  logic [2:0] bus_pins;
  logic cs_n;
  logic rd_n;
  logic interrupt_ack_cycle_n;
  logic [7:0] next_pin;
  logic [7:0] next_oe;
  logic any_irq;
  opm_bus_state_t bus_state;
  opm_bus_state_t next_bus_state;

  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > 8) $error("opm_output_mux supports 1 to 8 interrupt sources");
  end

  // host strobes come from pins and need synchronising
  opm_sync #(.WIDTH(3), .INIT(3'h7)) u_bus_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(clk_en_in),
    .async_in({interrupt_ack_cycle_n_in, read_n_in, chip_select_n_in}),
    .sync_out(bus_pins)
  );
  assign cs_n = bus_pins[0];
  assign rd_n = bus_pins[1];
  assign interrupt_ack_cycle_n = bus_pins[2];

  // open-drain drive: oe high means pull low
  function automatic logic [1:0] od_drive(input logic active);
    od_drive = {active, 1'b0};
  endfunction

  always_comb begin
    next_pin = gp_latch_in;
    next_oe = 8'hFF;
    if (op1_alt_in) begin
      next_pin[1] = ~chan_b_rts_in;
    end
    case (op3_sel_in)
      `OPM_OP3_SEL_TXCLK: next_pin[3] = chan_b_tx_unit_clock_in;
      `OPM_OP3_SEL_RXCLK: next_pin[3] = chan_b_rx_unit_clock_in;
      `OPM_OP3_SEL_CTRDY: {next_oe[3], next_pin[3]} = od_drive(ct_ready_in);
      default: next_pin[3] = gp_latch_in[3];
    endcase
    if (op5_alt_in) begin
      {next_oe[5], next_pin[5]} = od_drive(op5_fifo_full_sel_in ?
        chan_b_fifo_full_in : chan_b_rx_avail_in);
    end
    if (op6_alt_in) begin
      {next_oe[6], next_pin[6]} = od_drive(chan_a_tx_space_in);
    end
    if (op7_alt_in) begin
      {next_oe[7], next_pin[7]} = od_drive(chan_b_tx_space_in);
    end
  end

  // pin latch feeds from config; reset value selects latch high everywhere
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      general_output_out <= `OPM_GP_RESET;
      general_output_oe_out <= 8'hFF;
    end else if (clk_en_in) begin
      general_output_out <= next_pin;
      general_output_oe_out <= next_oe;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ct_stop_out <= 1'b1;
    end else if (clk_en_in) begin
      ct_stop_out <= 1'b0;
    end
  end

  // level, not sticky: releases only once every cause is gone
  assign any_irq = |(irq_cond_in & irq_mask_in);
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_request_n_out <= 1'b0;
      irq_request_oe_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_request_n_out <= 1'b0;
      irq_request_oe_out <= any_irq;
    end
  end

  always_comb begin
    next_bus_state = OPM_BUS_IDLE;
    if (vectored_mode_in && !interrupt_ack_cycle_n) begin
      next_bus_state = OPM_BUS_ACK;
    end else if (!cs_n && !rd_n) begin
      next_bus_state = OPM_BUS_READ;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      bus_state <= OPM_BUS_IDLE;
    end else if (clk_en_in) begin
      bus_state <= next_bus_state;
    end
  end

  // drive registered from next_bus_state so oe and data line up
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      data_bus_out <= 8'h00;
      data_bus_oe_out <= 1'b0;
    end else if (clk_en_in) begin
      case (next_bus_state)
        OPM_BUS_ACK: begin
          data_bus_out <= vector_in;
          data_bus_oe_out <= 1'b1;
        end
        OPM_BUS_READ: begin
          data_bus_out <= read_data_in;
          data_bus_oe_out <= 1'b1;
        end
        default: begin
          data_bus_out <= 8'h00;
          data_bus_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // write data sampled straight off the pins, bit 0 lsb
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      write_data_out <= 8'h00;
    end else if (clk_en_in) begin
      write_data_out <= data_bus_in;
    end
  end
endmodule // opm_output_mux

// >>> hw/opm_cfg.svh
// timing and encoding constants for the output port function mux
`ifndef OPM_CFG_SVH
`define OPM_CFG_SVH
`define OPM_GP_RESET 8'hFF
`define OPM_OP3_SEL_GP 2'h0
`define OPM_OP3_SEL_TXCLK 2'h1
`define OPM_OP3_SEL_RXCLK 2'h2
`define OPM_OP3_SEL_CTRDY 2'h3
`define OPM_SYNC_DEPTH 3
`endif

// >>> hw/opm_pkg.sv
// types for the output port function mux
`include "opm_cfg.svh"
package opm_pkg;
  typedef logic [1:0] opm_op3_sel_t;
  typedef enum logic [1:0] {
    OPM_BUS_IDLE = 2'b00,
    OPM_BUS_READ = 2'b01,
    OPM_BUS_ACK = 2'b10
  } opm_bus_state_t;
endpackage

// >>> hw/opm_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module opm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic enable_in,
  // pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  initial begin
    if (WIDTH < 1) $error("opm_sync width must be positive");
  end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else if (enable_in) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end
  // value moves only once the last two stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          sync_out[i] <= INIT[i];
        end else if (enable_in && (stage2[i] == stage3[i])) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule // opm_sync

// >>> verification/opm_output_mux_sva.sv
// pin, bus and interrupt assertions for the output port function mux
`timescale 1ns/100ps
module opm_output_mux_sva #(parameter int NUM_IRQ = 8) (
  // clock, reset, configuration
  input wire logic clk_in, reset_in, clk_en_in, op1_alt_in, op5_alt_in,
  input wire logic op5_fifo_full_sel_in, op6_alt_in, op7_alt_in,
  input wire logic [1:0] op3_sel_in,
  input wire logic [7:0] gp_latch_in, read_data_in,
  // status and host pins
  input wire logic chan_b_rts_in, ct_ready_in, chan_b_rx_avail_in, chan_b_fifo_full_in,
  input wire logic chan_b_tx_space_in, chan_a_tx_space_in, chip_select_n_in, read_n_in,
  input wire logic interrupt_ack_cycle_n_in,
  input wire logic [NUM_IRQ-1:0] irq_cond_in, irq_mask_in,
  // outputs
  input wire logic data_bus_oe_out, ct_stop_out, irq_request_n_out, irq_request_oe_out,
  input wire logic [7:0] data_bus_out, general_output_out, general_output_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // edges sampled in reset still carry reset values, so skip them
  wire live = clk_en_in && !reset_in;
  sequence s_rd; (!chip_select_n_in && !read_n_in && interrupt_ack_cycle_n_in)[*7]; endsequence
  sequence s_off; (chip_select_n_in && interrupt_ack_cycle_n_in)[*7]; endsequence
  property p_op1; $past(live) |-> general_output_out[1] ==
    ($past(op1_alt_in) ? !$past(chan_b_rts_in) : $past(gp_latch_in[1])); endproperty
  property p_op3; $past(live && op3_sel_in == 2'h3) |-> !general_output_out[3] &&
    general_output_oe_out[3] == $past(ct_ready_in); endproperty
  property p_op5; $past(live && op5_alt_in) |-> !general_output_out[5] &&
    general_output_oe_out[5] == $past(op5_fifo_full_sel_in ? chan_b_fifo_full_in :
    chan_b_rx_avail_in); endproperty
  property p_op6; $past(live && op6_alt_in) |-> !general_output_out[6] &&
    general_output_oe_out[6] == $past(chan_a_tx_space_in); endproperty
  property p_op7; $past(live && op7_alt_in) |-> !general_output_out[7] &&
    general_output_oe_out[7] == $past(chan_b_tx_space_in); endproperty
  property p_irq; $past(live) |-> !irq_request_n_out &&
    irq_request_oe_out == |$past(irq_cond_in & irq_mask_in); endproperty
  property p_read; s_rd |-> data_bus_oe_out && data_bus_out == read_data_in; endproperty
  property p_float; s_off |-> !data_bus_oe_out; endproperty
  property p_rst; disable iff (1'b0) reset_in |-> general_output_out == 8'hFF && ct_stop_out;
  endproperty
  a_op1: assert property (p_op1) else $error("op1 wrong");
  a_op3: assert property (p_op3) else $error("op3 wrong");
  a_op5: assert property (p_op5) else $error("op5 wrong");
  a_op6: assert property (p_op6) else $error("op6 wrong");
  a_op7: assert property (p_op7) else $error("op7 wrong");
  a_irq: assert property (p_irq) else $error("irq wrong");
  a_read: assert property (p_read) else $error("read wrong");
  a_float: assert property (p_float) else $error("bus driven");
  a_rst: assert property (p_rst) else $error("reset wrong");
endmodule // opm_output_mux_sva
bind opm_output_mux opm_output_mux_sva #(.NUM_IRQ(NUM_IRQ)) sva_u (.clk_in, .reset_in,
  .clk_en_in, .op1_alt_in, .op5_alt_in, .op5_fifo_full_sel_in, .op6_alt_in, .op7_alt_in,
  .op3_sel_in, .gp_latch_in, .read_data_in, .chan_b_rts_in, .ct_ready_in,
  .chan_b_rx_avail_in, .chan_b_fifo_full_in, .chan_b_tx_space_in, .chan_a_tx_space_in,
  .chip_select_n_in, .read_n_in, .interrupt_ack_cycle_n_in, .irq_cond_in, .irq_mask_in,
  .data_bus_oe_out, .ct_stop_out, .irq_request_n_out, .irq_request_oe_out, .data_bus_out,
  .general_output_out, .general_output_oe_out);

// >>> verification/opm_host_model.sv
// host cpu model driving chip select, read and acknowledge strobes
`timescale 1ns/100ps
module opm_host_model (
  // clock and bus
  input wire logic clk_in,
  input wire logic data_bus_oe_out,
  input wire logic [7:0] data_bus_out,
  // strobes
  output logic chip_select_n_out = 1,
  output logic read_n_out = 1,
  output logic ack_n_out = 1
);
  task automatic access(input logic ack, output logic [7:0] d, output logic ok);
    ok = 0;
    @(negedge clk_in);
    if (ack) ack_n_out = 0;
    else {chip_select_n_out, read_n_out} = 2'h0;
    // sample off the launching edge so the registered answer has settled
    for (int i = 0; i < 12 && !ok; i++) begin
      @(negedge clk_in);
      ok = data_bus_oe_out;
      d = data_bus_out;
    end
    // a slow host stretches the strobe past the answer
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    {chip_select_n_out, read_n_out, ack_n_out} = 3'h7;
  endtask
endmodule // opm_host_model

// >>> verification/opm_tb.sv
// self-checking bench for the output port function mux
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rst = 0, vm = 0, boe, cts, irn, iroe, csn, rdn, ackn, ok;
  logic [7:0] cfg = 0, st = 0, lat = 0, cnd = 0, msk = 0, d, go, goe, dbo, dbi, wd;
  int err_total = 0, checks = 0;
  // {cfg, status, latch, expected out, expected oe}
  logic [39:0] rows [4] = '{40'h00FFA5A5FF, 40'hB6CA0008BF, 40'hDE29FF1F5F, 40'h60000F07F7};
  // released bus reads all ones, the inverse of the zeros the mux leaves on data_bus_out
  assign dbi = boe ? dbo : ~dbo;
  initial forever #2 clk = ~clk;
  opm_output_mux dut_u (.clk_in(clk), .reset_in(rst), .clk_en_in(1'b1), .gp_latch_in(lat),
    .op1_alt_in(cfg[7]), .op3_sel_in(cfg[6:5]), .op5_alt_in(cfg[4]),
    .op5_fifo_full_sel_in(cfg[3]), .op6_alt_in(cfg[2]), .op7_alt_in(cfg[1]),
    .vectored_mode_in(vm), .chan_b_rts_in(st[7]), .chan_b_tx_unit_clock_in(st[6]),
    .chan_b_rx_unit_clock_in(st[5]), .ct_ready_in(st[4]), .chan_b_rx_avail_in(st[3]),
    .chan_b_fifo_full_in(st[2]), .chan_b_tx_space_in(st[1]), .chan_a_tx_space_in(st[0]),
    .irq_cond_in(cnd), .irq_mask_in(msk), .chip_select_n_in(csn), .read_n_in(rdn),
    .interrupt_ack_cycle_n_in(ackn), .read_data_in(8'h3C), .vector_in(8'hC3),
    .data_bus_in(dbi), .data_bus_out(dbo), .data_bus_oe_out(boe), .write_data_out(wd),
    .ct_stop_out(cts), .general_output_out(go), .general_output_oe_out(goe),
    .irq_request_n_out(irn), .irq_request_oe_out(iroe));
  opm_host_model host_u (.clk_in(clk), .data_bus_oe_out(boe), .data_bus_out(dbo),
    .chip_select_n_out(csn), .read_n_out(rdn), .ack_n_out(ackn));
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    // a real rising edge, so the asynchronous reset branches run
    #1 rst = 1;
    cyc(1);
    chk("rst_out", 8'hFF, go);
    chk("rst_stop", 8'h01, {7'h0, cts});
    cyc(4);
    rst = 0;
    cyc(2);
    chk("dflt_out", 8'h00, go);
    chk("run_stop", 8'h00, {7'h0, cts});
    foreach (rows[i]) begin
      {cfg, st, lat} = rows[i][39:16];
      cyc(3);
      chk("pin_out", rows[i][15:8], go);
      chk("pin_oe", rows[i][7:0], goe);
    end
    cnd = 8'h04;
    cyc(2);
    chk("irq_masked", 8'h00, {7'h0, iroe});
    msk = 8'h04;
    cyc(4);
    chk("irq_held", 8'h01, {7'h0, iroe});
    chk("irq_level", 8'h00, {7'h0, irn});
    cnd = 8'h00;
    cyc(2);
    chk("irq_off", 8'h00, {7'h0, iroe});
    host_u.access(1'b0, d, ok);
    chk("rd_done", 8'h01, {7'h0, ok});
    if (ok !== 1'b1) tally_and_finish;
    chk("rd_data", 8'h3C, d);
    chk("wr_data", 8'h3C, wd);
    cyc(8);
    chk("bus_float", 8'h00, {7'h0, boe});
    host_u.access(1'b1, d, ok);
    chk("ack_refused", 8'h00, {7'h0, ok});
    cyc(8);
    vm = 1;
    host_u.access(1'b1, d, ok);
    chk("ack_done", 8'h01, {7'h0, ok});
    if (ok !== 1'b1) tally_and_finish;
    chk("ack_vec", 8'hC3, d);
    chk("wr_vec", 8'hC3, wd);
    vm = 0;
    cyc(8);
    rst = 1;
    cyc(1);
    chk("rst2_out", 8'hFF, go);
    chk("rst2_oe", 8'hFF, goe);
    rst = 0;
    cyc(2);
    chk("rel2_out", 8'h07, go);
    tally_and_finish;
  end
endmodule // testbench
